// [bench/async_event_counter_bench.sv]
// Self-checking bench for the event counter block
`timescale 1ns/1ps
module async_event_counter_bench;
    import event_counter_pkg::*;

    localparam logic [ADDR_W-1:0] A_CTRL = {CTRL_STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_UPPER = {COUNT_UPPER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_LOWER = {COUNT_LOWER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_PORT = {PORT_MODE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_IEN = {IRQ_ENABLE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_IRQ = {IRQ_REQUEST_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_NONE = 18'h00010;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic lower_event_pin;
    logic upper_event_pin;
    logic irq_out;
    int miscompares = 0;
    int n_checks = 0;

    always #12.5 pclk = ~pclk;

    event_counter_top DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lower_event_pin(lower_event_pin),
        .upper_event_pin(upper_event_pin), .irq_out(irq_out)
    );

    event_source src (
        .pclk(pclk),
        .lower_event_pin(lower_event_pin),
        .upper_event_pin(upper_event_pin)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [DATA_W-1:0] r;
        logic e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask : wr

    task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [DATA_W-1:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(name, r, {24'h000000, exp});
        check({name, " error"}, {31'h0, e}, 32'h0000_0000);
    endtask : rd

    task automatic t_reset();
        logic [DATA_W-1:0] r;
        logic e;
        rd("ctrl", A_CTRL, 8'h00);
        rd("upper", A_UPPER, 8'h00);
        rd("lower", A_LOWER, 8'h00);
        rd("irq request", A_IRQ, 8'h00);
        apb(1'b0, A_NONE, 32'h0000_0000, r, e);
        check("unmapped error", {31'h0, e}, 32'h0000_0001);
        check("unmapped data", r, 32'h0000_0000);
        @(negedge pclk);
        check("reset irq", {31'h0, irq_out}, 32'h0000_0000);
    endtask : t_reset

    task automatic t_gating();
        wr(A_CTRL, 8'h05);
        src.pulse(1'b0, 3);
        rd("lower unrouted", A_LOWER, 8'h00);
        wr(A_PORT, 8'h80);
        wr(A_CTRL, 8'h01);
        src.pulse(1'b0, 3);
        rd("lower disabled", A_LOWER, 8'h00);
        wr(A_CTRL, 8'h04);
        src.pulse(1'b0, 3);
        rd("lower held", A_LOWER, 8'h00);
        wr(A_CTRL, 8'h05);
        src.pulse(1'b0, 3);
        rd("lower counted", A_LOWER, 8'h03);
    endtask : t_gating

    task automatic t_cascade();
        wr(A_CTRL, 8'h0C);
        wr(A_CTRL, 8'h0F);
        src.pulse(1'b0, 261);
        rd("cascade lower", A_LOWER, 8'h05);
        rd("cascade upper", A_UPPER, 8'h01);
        rd("cascade ctrl", A_CTRL, 8'h0F);
        src.pulse(1'b1, 4);
        rd("upper pin ignored", A_UPPER, 8'h01);
        wr(A_CTRL, 8'h07);
        src.pulse(1'b0, 256);
        rd("upper disabled", A_UPPER, 8'h01);
    endtask : t_cascade

    task automatic t_split();
        wr(A_IEN, 8'h00);
        wr(A_CTRL, 8'h1C);
        wr(A_CTRL, 8'h1F);
        src.pulse(1'b1, 255);
        rd("split upper", A_UPPER, 8'hFF);
        rd("no flag yet", A_CTRL, 8'h1F);
        src.pulse(1'b1, 1);
        rd("upper wrapped", A_UPPER, 8'h00);
        rd("upper flag", A_CTRL, 8'h9F);
        rd("pending", A_IRQ, 8'h01);
        @(negedge pclk);
        check("irq masked", {31'h0, irq_out}, 32'h0000_0000);
        src.pulse(1'b0, 256);
        rd("lower flag", A_CTRL, 8'hDF);
        wr(A_CTRL, 8'hDF);
        rd("flags kept", A_CTRL, 8'hDF);
        wr(A_IRQ, 8'h01);
        rd("pending kept", A_IRQ, 8'h01);
        wr(A_IEN, 8'h01);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("irq enabled", {31'h0, irq_out}, 32'h0000_0001);
        wr(A_CTRL, 8'h1F);
        rd("flags cleared", A_CTRL, 8'h1F);
        wr(A_IRQ, 8'h00);
        rd("pending cleared", A_IRQ, 8'h00);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("irq dropped", {31'h0, irq_out}, 32'h0000_0000);
        src.pulse(1'b1, 2);
        wr(A_CTRL, 8'h1D);
        rd("upper held", A_UPPER, 8'h00);
    endtask : t_split

    // Load both halves to FF in split mode, then cascade and wrap the full count
    task automatic t_full_wrap();
        wr(A_CTRL, 8'h1C);
        wr(A_CTRL, 8'h1F);
        src.pulse(1'b1, 255);
        src.pulse(1'b0, 255);
        wr(A_CTRL, 8'h0F);
        rd("full upper", A_UPPER, 8'hFF);
        rd("full lower", A_LOWER, 8'hFF);
        rd("full no flag", A_CTRL, 8'h0F);
        src.pulse(1'b0, 1);
        rd("wrap lower", A_LOWER, 8'h00);
        rd("wrap upper", A_UPPER, 8'h00);
        rd("wrap flags", A_CTRL, 8'h8F);
        rd("wrap pending", A_IRQ, 8'h01);
        @(negedge pclk);
        check("wrap irq", {31'h0, irq_out}, 32'h0000_0001);
        src.pulse(1'b0, 1);
        rd("wrap continues", A_LOWER, 8'h01);
    endtask : t_full_wrap

    initial begin
        #(25 * 20000);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gating();
        t_cascade();
        t_split();
        t_full_wrap();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        conclude();
    end
endmodule : async_event_counter_bench

// [bench/event_source.sv]
// Event pulse source on the two counter pins
`timescale 1ns/1ps
module event_source (
    input wire logic pclk,
    output logic lower_event_pin,
    output logic upper_event_pin
);
    initial begin
        lower_event_pin = 1'b0;
        upper_event_pin = 1'b0;
    end

    // Each event is one high cycle followed by one low cycle
    task automatic pulse(input bit upper, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (upper) begin
                upper_event_pin <= 1'b1;
            end else begin
                lower_event_pin <= 1'b1;
            end
            @(posedge pclk);
            upper_event_pin <= 1'b0;
            lower_event_pin <= 1'b0;
        end
        @(posedge pclk);
    endtask : pulse
endmodule : event_source

// [rtl/byte_counter.sv]
// Up-counter with reset-hold and wrap pulse
`timescale 1ns/1ps
module byte_counter
    import event_counter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    count_if.counter cif
);
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic at_max;

    assign at_max = (count_reg == COUNT_MAX);
    assign cif.wrap = cif.inc & ~cif.hold & at_max;
    assign count_next = cif.hold ? COUNT_RESET :
                        cif.inc ? COUNT_W'(count_reg + 1'b1) : count_reg;
    assign cif.count = count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : byte_counter

// [rtl/count_if.sv]
// Control and state of one byte counter
`timescale 1ns/1ps
interface count_if #(
    parameter int WIDTH = 8
);
    logic inc;
    logic hold;
    logic [WIDTH-1:0] count;
    logic wrap;

    modport counter (
        input inc,
        input hold,
        output count,
        output wrap
    );
    modport ctrl (
        output inc,
        output hold,
        input count,
        input wrap
    );
endinterface : count_if

// [rtl/event_counter_pkg.sv]
// Register map, field positions and reset values of the event counter
package event_counter_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 8;

    // Register indices; the APB byte address is four times the index
    localparam logic [15:0] CTRL_STATUS_IDX = 16'hFF95;
    localparam logic [15:0] COUNT_UPPER_IDX = 16'hFF96;
    localparam logic [15:0] COUNT_LOWER_IDX = 16'hFF97;
    localparam logic [15:0] PORT_MODE_IDX = 16'hFFCA;
    localparam logic [15:0] IRQ_ENABLE_IDX = 16'hFFF4;
    localparam logic [15:0] IRQ_REQUEST_IDX = 16'hFFF7;

    // Control/status fields
    localparam int UPPER_OVF_BIT = 7;
    localparam int LOWER_OVF_BIT = 6;
    localparam int SPLIT_BIT = 4;
    localparam int UPPER_EN_BIT = 3;
    localparam int LOWER_EN_BIT = 2;
    localparam int UPPER_REL_BIT = 1;
    localparam int LOWER_REL_BIT = 0;
    localparam int CTRL_FIELD_W = 5;

    // Port mode and interrupt fields
    localparam int ROUTE_BIT = 7;
    localparam int IRQ_PEND_BIT = 0;
    localparam int IRQ_EN_BIT = 0;

    // Reset values and counter maximum
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
endpackage : event_counter_pkg

// [rtl/event_counter_top.sv]
// Two byte event counters, cascaded or split, with APB registers
// Overview of operation
// R1: Bit 7 at FF95 flags upper overflow
// R2: Bit 6 flags lower counter overflow
// R3: Bit 4 selects cascaded or split counters
// R4: Upper enable bit gates upper counter events
// R5: Bit 2 gates lower counter events
// R6: Bit 1 low holds upper counter cleared
// R7: Bit 0 low holds lower counter cleared
// R8: Upper count readable at FF96, high byte
// R9: Lower count readable at FF97, low byte
// R10: FFF7 bit 0 shows pending request
// R11: FFF4 bit 0 gates request to processor
// R12: FFCA bit 7 routes pin to lower
// R13: Cascade FFFF wraps, flags upper, requests interrupt
// R14: Upper clocked by lower wrap or pin
// R15: Pending request stays until software writes 0
// R16: Reset clears control/status to zero
// R17: Overflow flags clear only by writing 0
// R18: Split mode: each wraps, flags, requests
`timescale 1ns/1ps
module event_counter_top
    import event_counter_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lower_event_pin,
    input wire logic upper_event_pin,
    output logic irq_out
);
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] UPPER_ADDR = {COUNT_UPPER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] LOWER_ADDR = {COUNT_LOWER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PMODE_ADDR = {PORT_MODE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IEN_ADDR = {IRQ_ENABLE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_ADDR = {IRQ_REQUEST_IDX, 2'b00};

    // Registers
    logic [CTRL_FIELD_W-1:0] ctrl_reg;
    logic [CTRL_FIELD_W-1:0] ctrl_next;
    logic upper_ovf_reg;
    logic upper_ovf_next;
    logic lower_ovf_reg;
    logic lower_ovf_next;
    logic route_reg;
    logic route_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic irq_pend_reg;
    logic irq_pend_next;
    logic irq_out_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic pready_reg;
    logic pslverr_reg;

    // Bus decode
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic sel_ctrl;
    logic sel_upper;
    logic sel_lower;
    logic sel_pmode;
    logic sel_ien;
    logic sel_irq;
    logic addr_hit;
    logic wr_ctrl;

    // Counter control
    logic split_mode;
    logic upper_en;
    logic lower_en;
    logic upper_rel;
    logic lower_rel;
    logic lower_pin_rise;
    logic upper_pin_rise;
    logic upper_set;
    logic lower_set;
    logic irq_set;

    count_if #(.WIDTH(COUNT_W)) lower_cif ();
    count_if #(.WIDTH(COUNT_W)) upper_cif ();

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready_reg;
    assign wr_done = access_done & pwrite;
    assign sel_ctrl = (paddr == CTRL_ADDR);
    assign sel_upper = (paddr == UPPER_ADDR);
    assign sel_lower = (paddr == LOWER_ADDR);
    assign sel_pmode = (paddr == PMODE_ADDR);
    assign sel_ien = (paddr == IEN_ADDR);
    assign sel_irq = (paddr == IRQ_ADDR);
    assign addr_hit = sel_ctrl | sel_upper | sel_lower | sel_pmode | sel_ien | sel_irq;
    assign wr_ctrl = wr_done & sel_ctrl;

    assign split_mode = ctrl_reg[SPLIT_BIT];  // see R3
    assign upper_en = ctrl_reg[UPPER_EN_BIT];
    assign lower_en = ctrl_reg[LOWER_EN_BIT];
    assign upper_rel = ctrl_reg[UPPER_REL_BIT];
    assign lower_rel = ctrl_reg[LOWER_REL_BIT];

    // Lower pin counts only when routed to the counter
    event_edge u_lower_edge (
        .clk(pclk),
        .rst_n(presetn),
        .pin(lower_event_pin),
        .enable(route_reg & lower_en),  // see R12 see R5
        .rise(lower_pin_rise)
    );

    event_edge u_upper_edge (
        .clk(pclk),
        .rst_n(presetn),
        .pin(upper_event_pin),
        .enable(upper_en & split_mode),
        .rise(upper_pin_rise)
    );

    assign lower_cif.inc = lower_pin_rise;
    assign lower_cif.hold = ~lower_rel;  // see R7
    // Upper source: lower wrap when cascaded, own pin when split
    assign upper_cif.inc = split_mode ? upper_pin_rise
                                      : (lower_cif.wrap & upper_en);  // see R14 see R4
    assign upper_cif.hold = ~upper_rel;  // see R6

    byte_counter u_lower (
        .clk(pclk),
        .rst_n(presetn),
        .cif(lower_cif)
    );

    byte_counter u_upper (
        .clk(pclk),
        .rst_n(presetn),
        .cif(upper_cif)
    );

    // Overflow events; in cascade only the full 16-bit wrap flags
    assign upper_set = upper_cif.wrap;  // see R1 see R13
    assign lower_set = lower_cif.wrap & split_mode;  // see R2 see R18
    assign irq_set = upper_set | lower_set;

    // Flags: set wins over a write of 0, a write of 1 changes nothing
    assign upper_ovf_next = upper_set |
        (upper_ovf_reg & ~(wr_ctrl & ~pwdata[UPPER_OVF_BIT]));  // see R17
    assign lower_ovf_next = lower_set |
        (lower_ovf_reg & ~(wr_ctrl & ~pwdata[LOWER_OVF_BIT]));  // see R17
    assign irq_pend_next = irq_set |
        (irq_pend_reg & ~(wr_done & sel_irq & ~pwdata[IRQ_PEND_BIT]));  // see R15
    assign ctrl_next = wr_ctrl ? pwdata[CTRL_FIELD_W-1:0] : ctrl_reg;
    assign route_next = (wr_done & sel_pmode) ? pwdata[ROUTE_BIT] : route_reg;
    assign irq_en_next = (wr_done & sel_ien) ? pwdata[IRQ_EN_BIT] : irq_en_reg;

    // Read data, captured in the setup phase
    assign rdata_next =
        sel_ctrl ? {24'h00_0000, upper_ovf_reg, lower_ovf_reg, 1'b0, ctrl_reg} :  // see R1 see R2
        sel_upper ? {24'h00_0000, upper_cif.count} :  // see R8
        sel_lower ? {24'h00_0000, lower_cif.count} :  // see R9
        sel_pmode ? {24'h00_0000, route_reg, 7'h00} :
        sel_ien ? {31'h0000_0000, irq_en_reg} :
        sel_irq ? {31'h0000_0000, irq_pend_reg} :  // see R10
        RDATA_RESET;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;  // see R16
            upper_ovf_reg <= 1'b0;
            lower_ovf_reg <= 1'b0;
            route_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            upper_ovf_reg <= upper_ovf_next;
            lower_ovf_reg <= lower_ovf_next;
            route_reg <= route_next;
            irq_en_reg <= irq_en_next;
            irq_pend_reg <= irq_pend_next;
        end
    end

    // Request reaches the processor only when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out_reg <= 1'b0;
        end else begin
            irq_out_reg <= irq_pend_reg & irq_en_reg;  // see R11
        end
    end

    // APB answer: one access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= RDATA_RESET;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase & ~addr_hit;
            if (setup_phase) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign prdata = rdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_out = irq_out_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cascade_full;
        !split_mode && upper_en && upper_rel && lower_rel &&
        lower_cif.inc && lower_cif.count == 8'hFF && upper_cif.count == 8'hFF;
    endsequence

    sequence s_cascade_wrapped;
        upper_cif.count == 8'h00 && lower_cif.count == 8'h00 &&
        upper_ovf_reg && irq_pend_reg;
    endsequence

    a_cascade_full_wrap: assert property (s_cascade_full |=> s_cascade_wrapped)  // see R13
        else $error("cascade wrap did not clear counts and set flags");

    a_lower_hold_clear: assert property (!lower_rel |=> lower_cif.count == 8'h00)  // see R7
        else $error("lower counter not held at zero");

    a_upper_hold_clear: assert property (!upper_rel |=> upper_cif.count == 8'h00)  // see R6
        else $error("upper counter not held at zero");

    a_upper_gate_off: assert property (!upper_en && upper_rel |=> $stable(upper_cif.count))  // see R4
        else $error("upper counter moved while disabled");

    a_route_gate_off: assert property (
        (!route_reg || !lower_en) && lower_rel |=> $stable(lower_cif.count))  // see R12
        else $error("lower counter moved without routed enabled pin");

    a_ovf_sticky_hold: assert property (
        upper_ovf_reg && !(wr_ctrl && !pwdata[UPPER_OVF_BIT]) |=> upper_ovf_reg)  // see R17
        else $error("upper overflow flag lost without a write of zero");

    a_split_lower_flag: assert property (lower_set |=> lower_ovf_reg && irq_pend_reg)  // see R18
        else $error("split lower wrap did not flag and request");

    a_irq_out_gate: assert property (
        irq_pend_reg && irq_en_reg ##1 irq_pend_reg && irq_en_reg |-> irq_out)  // see R11
        else $error("enabled pending request not forwarded");

    a_irq_mask_off: assert property (!irq_en_reg |=> !irq_out)  // see R11
        else $error("request forwarded while disabled");

    a_irq_pend_stay: assert property (
        irq_pend_reg && !(wr_done && sel_irq) |=> irq_pend_reg)  // see R15
        else $error("pending request cleared without a write");

    a_apb_ready_once: assert property (setup_phase |=> pready ##1 !pready)
        else $error("access phase not exactly one cycle");
endmodule : event_counter_top

// [rtl/event_edge.sv]
// Rising-edge detector for an event pin, gated by an enable
`timescale 1ns/1ps
module event_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic enable,
    output logic rise
);
    logic pin_d_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= pin;
        end
    end

    assign rise = enable & pin & ~pin_d_reg;
endmodule : event_edge
